// File: src/vcmc_map.svh
`ifndef VCMC_MAP_SVH
`define VCMC_MAP_SVH
`define VCMC_OFF_CTRL 8'h00
`define VCMC_OFF_STRB 8'h04
`define VCMC_OFF_STAT 8'h08
`define VCMC_OFF_MPP 8'h0C
`define VCMC_OFF_CH0 8'h10
`define VCMC_OFF_CH_LAST 8'h2C
`define VCMC_CH_MODE_POS 0
`define VCMC_CH_SRC_POS 2
`define VCMC_CH_PBEN_POS 4
`define VCMC_CH_FRZ_POS 5
`define VCMC_CH_SKIP_POS 6
`define VCMC_CH_EN_POS 7
`define VCMC_CTRL_FLD_POS 0
`define VCMC_CTRL_SIM_POS 2
`define VCMC_CTRL_HOLD_POS 3
`define VCMC_CTRL_SWFRM_POS 4
`define VCMC_CH_RESET 8'h80
`define VCMC_CTRL_RESET 5'h00
`define VCMC_MPP_RESET 4'h0
`define VCMC_BAD_WORD 32'hDEADBEEF
`endif

// File: src/vcmc_pkg.sv
`default_nettype none
package vcmc_pkg;
	typedef enum logic [1:0] {
		VCMC_LIVE = 2'b00,
		VCMC_STROBE = 2'b01,
		VCMC_SWITCH = 2'b10,
		VCMC_RSVD = 2'b11
	} vcmc_mode_type;
	typedef enum logic [1:0] {
		VCMC_ODD = 2'b00,
		VCMC_EVEN = 2'b01,
		VCMC_ANY = 2'b10,
		VCMC_FRAME = 2'b11
	} vcmc_fld_type;
	typedef struct packed {
		logic fs;
		logic odd;
	} vcmc_vid_type;
	typedef struct packed {
		logic [3:0] src;
		logic valid;
	} vcmc_pic_type;
endpackage
`default_nettype wire

// File: src/vcmc_top.sv
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vcmc_map.svh"
module vcmc_top (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// per-channel input video timing (pins), ch 0-3 display, 4-7 record
	input wire logic [7:0] i_field_start,
	input wire logic [7:0] i_field_odd,
	// switch requests, one pulse per channel, from the switch sequencer
	input wire logic [7:0] i_switch_req,
	input wire logic [31:0] i_switch_src,
	// axi4-lite slave
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// picture selection per channel, 4 bits each
	output logic [31:0] o_pic_src,
	output logic [7:0] o_pic_load,
	// auxiliary multipurpose outputs
	output logic [1:0] o_aux_pins
);
	import vcmc_pkg::*;

	localparam int NCH = 8;

	logic [7:0] fs_m_ff, fs_s_ff, fs_d_ff, odd_m_ff, odd_s_ff;
	logic [7:0] chcfg_ff [NCH];
	logic [4:0] ctrl_ff;
	logic [3:0] mpp_ff;
	logic [7:0] req_ff, done_ff;
	logic [31:0] pend_src_ff;
	logic [7:0] aw_addr_ff;
	logic aw_ok_ff, w_ok_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic [31:0] hold_src_ff;
	logic [7:0] frame_half_ff;

	vcmc_vid_type vid [NCH];
	logic [7:0] fs_pulse;
	logic wr_go;
	logic [7:0] strb_wr;
	logic [7:0] strb_ok;
	logic [7:0] ev_capture;
	logic all_done;

	function automatic logic [3:0] eff_src(input logic [7:0] cfg, input int ch);
		logic [3:0] s;
		s = {2'b00, cfg[`VCMC_CH_SRC_POS +: 2]};
		if (ch < 4 && cfg[`VCMC_CH_PBEN_POS])
			s = 4'h4 | s;
		return s;
	endfunction

	function automatic logic fld_hit(input vcmc_fld_type f, input logic odd, input logic half);
		logic h;
		h = 1'b0;
		case (f)
			VCMC_ODD: h = odd;
			VCMC_EVEN: h = !odd;
			VCMC_ANY: h = 1'b1;
			VCMC_FRAME: h = half;
			default: h = 1'b0;
		endcase
		return h;
	endfunction

	// two-stage sync of video timing pins
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fs_m_ff <= 8'h00;
			fs_s_ff <= 8'h00;
			fs_d_ff <= 8'h00;
			odd_m_ff <= 8'h00;
			odd_s_ff <= 8'h00;
		end else begin
			fs_m_ff <= i_field_start;
			fs_s_ff <= fs_m_ff;
			fs_d_ff <= fs_s_ff;
			odd_m_ff <= i_field_odd;
			odd_s_ff <= odd_m_ff;
		end
	end
	assign fs_pulse = fs_s_ff & ~fs_d_ff;

	// frame phase: second field of an odd-even pair closes a frame
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			frame_half_ff <= 8'h00;
		else
			for (int c = 0; c < NCH; c++)
				if (fs_pulse[c])
					frame_half_ff[c] <= odd_s_ff[c];
	end

	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			vid[c].fs = fs_pulse[c];
			vid[c].odd = odd_s_ff[c];
		end
	end

	// axi write channel capture, either order
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			aw_ok_ff <= 1'b0;
			w_ok_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff <= 32'h0;
			w_strb_ff <= 4'h0;
			o_awready <= 1'b0;
			o_wready <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= 2'b00;
		end else begin
			o_awready <= !aw_ok_ff && !o_awready && !o_bvalid;
			o_wready <= !w_ok_ff && !o_wready && !o_bvalid;
			if (i_awvalid && o_awready) begin
				aw_ok_ff <= 1'b1;
				aw_addr_ff <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_ok_ff <= 1'b1;
				w_data_ff <= i_wdata;
				w_strb_ff <= i_wstrb;
			end
			if (wr_go) begin
				aw_ok_ff <= 1'b0;
				w_ok_ff <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= (aw_addr_ff > `VCMC_OFF_CH_LAST || aw_addr_ff[1:0] != 2'b00)
					? 2'b10 : 2'b00;
			end else if (o_bvalid && i_bready)
				o_bvalid <= 1'b0;
		end
	end
	assign wr_go = aw_ok_ff && w_ok_ff && !o_bvalid;
	assign strb_wr = (wr_go && aw_addr_ff == `VCMC_OFF_STRB && w_strb_ff[0])
		? w_data_ff[7:0] : 8'h00;

	// per-channel configuration; busy strobe channel refuses leaving strobe
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int c = 0; c < NCH; c++)
				chcfg_ff[c] <= `VCMC_CH_RESET;
			ctrl_ff <= `VCMC_CTRL_RESET;
			mpp_ff <= `VCMC_MPP_RESET;
		end else if (wr_go && w_strb_ff[0]) begin
			if (aw_addr_ff == `VCMC_OFF_CTRL)
				ctrl_ff <= w_data_ff[4:0];
			if (aw_addr_ff == `VCMC_OFF_MPP)
				mpp_ff <= w_data_ff[3:0];
			for (int c = 0; c < NCH; c++)
				if (aw_addr_ff == `VCMC_OFF_CH0 + 8'(4 * c)) begin
					if (req_ff[c] && w_data_ff[1:0] != VCMC_STROBE)
						chcfg_ff[c] <= {w_data_ff[7:2], chcfg_ff[c][1:0]};
					else
						chcfg_ff[c] <= w_data_ff[7:0];
				end
		end
	end

	// strobe request flags; simultaneous-release clear wins over a new set
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			strb_ok[c] = chcfg_ff[c][1:0] == VCMC_STROBE && !chcfg_ff[c][`VCMC_CH_FRZ_POS];
			ev_capture[c] = req_ff[c] && !done_ff[c] && vid[c].fs
				&& fld_hit(vcmc_fld_type'(ctrl_ff[1:0]), vid[c].odd, frame_half_ff[c]);
		end
	end
	assign all_done = (req_ff & ~done_ff) == 8'h00;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			req_ff <= 8'h00;
			done_ff <= 8'h00;
			pend_src_ff <= 32'h0;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (strb_wr[c] && !req_ff[c] && strb_ok[c]) begin
					req_ff[c] <= 1'b1;
					done_ff[c] <= 1'b0;
				end else if (strb_wr[c] && !req_ff[c]) begin
					req_ff[c] <= 1'b0;
				end else if (ev_capture[c]) begin
					pend_src_ff[4*c +: 4] <= eff_src(chcfg_ff[c], c);
					if (ctrl_ff[`VCMC_CTRL_SIM_POS])
						done_ff[c] <= 1'b1;
					else
						req_ff[c] <= 1'b0;
				end else if (!strb_ok[c] && req_ff[c] && !done_ff[c]) begin
					req_ff[c] <= 1'b0;
				end
			end
			if (ctrl_ff[`VCMC_CTRL_SIM_POS] && req_ff != 8'h00 && all_done) begin
				req_ff <= 8'h00;
				done_ff <= 8'h00;
			end
			if (!ctrl_ff[`VCMC_CTRL_SIM_POS])
				done_ff <= 8'h00;
		end
	end

	// picture outputs: live, strobe, switch
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_pic_src <= 32'h0;
			o_pic_load <= 8'h00;
			hold_src_ff <= 32'h0;
		end else begin
			o_pic_load <= 8'h00;
			for (int c = 0; c < NCH; c++) begin
				case (vcmc_mode_type'(chcfg_ff[c][1:0]))
					VCMC_LIVE: begin
						if (vid[c].fs) begin
							o_pic_src[4*c +: 4] <= eff_src(chcfg_ff[c], c);
							o_pic_load[c] <= 1'b1;
						end
					end
					VCMC_STROBE: begin
						if (ev_capture[c] && !ctrl_ff[`VCMC_CTRL_SIM_POS]) begin
							o_pic_src[4*c +: 4] <= eff_src(chcfg_ff[c], c);
							o_pic_load[c] <= 1'b1;
						end
					end
					VCMC_SWITCH: begin
						if (i_switch_req[c] && chcfg_ff[c][`VCMC_CH_EN_POS]
							&& !chcfg_ff[c][`VCMC_CH_FRZ_POS]
							&& !chcfg_ff[c][`VCMC_CH_SKIP_POS])
							hold_src_ff[4*c +: 4] <= (c >= 4)
								? {2'b00, i_switch_src[4*c +: 2]} : i_switch_src[4*c +: 4];
						if (vid[c].fs && (!ctrl_ff[`VCMC_CTRL_SWFRM_POS] || !vid[c].odd)) begin
							if (ctrl_ff[`VCMC_CTRL_HOLD_POS]
								|| o_pic_src[4*c +: 4] != hold_src_ff[4*c +: 4]) begin
								o_pic_src[4*c +: 4] <= hold_src_ff[4*c +: 4];
								o_pic_load[c] <= 1'b1;
							end
						end
					end
					default: o_pic_load[c] <= 1'b0;
				endcase
			end
			if (ctrl_ff[`VCMC_CTRL_SIM_POS] && req_ff != 8'h00 && all_done) begin
				for (int c = 0; c < NCH; c++)
					if (done_ff[c]) begin
						o_pic_src[4*c +: 4] <= pend_src_ff[4*c +: 4];
						o_pic_load[c] <= 1'b1;
					end
			end
		end
	end

	// auxiliary pins show flag pair chosen by config; pairs above 3 do not exist
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			o_aux_pins <= 2'b00;
		else if (mpp_ff[0] && !mpp_ff[3])
			o_aux_pins <= req_ff[2*mpp_ff[3:1] +: 2];
		else
			o_aux_pins <= 2'b00;
	end

	// axi read
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0;
			o_rresp <= 2'b00;
		end else begin
			o_arready <= !o_rvalid && !o_arready;
			if (i_arvalid && o_arready) begin
				o_rvalid <= 1'b1;
				o_rresp <= 2'b00;
				o_rdata <= 32'h0;
				if (i_araddr == `VCMC_OFF_CTRL)
					o_rdata <= {27'h0, ctrl_ff};
				else if (i_araddr == `VCMC_OFF_STRB || i_araddr == `VCMC_OFF_STAT)
					o_rdata <= {24'h0, req_ff};
				else if (i_araddr == `VCMC_OFF_MPP)
					o_rdata <= {28'h0, mpp_ff};
				else if (i_araddr >= `VCMC_OFF_CH0 && i_araddr <= `VCMC_OFF_CH_LAST
					&& i_araddr[1:0] == 2'b00)
					o_rdata <= {24'h0, chcfg_ff[i_araddr[4:2] ^ 3'b100]}; // channel 0 sits at 0x10
				else begin
					o_rresp <= 2'b10;
					o_rdata <= `VCMC_BAD_WORD;
				end
			end else if (o_rvalid && i_rready)
				o_rvalid <= 1'b0;
		end
	end

	chk_strobe_clear_nonstrobe: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(strb_wr[0] && !req_ff[0] && !strb_ok[0]) |=> !req_ff[0])
		else $error("refused strobe left flag set");
	chk_busy_keeps_mode: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		req_ff[0] |=> (chcfg_ff[0][1:0] == VCMC_STROBE || !$past(strb_ok[0])))
		else $error("busy channel left strobe mode");
	chk_strobe_sets_flag: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(strb_wr[1] && !req_ff[1] && strb_ok[1]) |=> req_ff[1])
		else $error("strobe did not set flag");
	chk_capture_clears_flag: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(ev_capture[0] && !ctrl_ff[2] && !strb_wr[0]) |=> !req_ff[0] ##1 o_pic_load[0] == 1'b0)
		else $error("flag not cleared after capture");
	chk_live_refresh: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(fs_pulse[2] && chcfg_ff[2][1:0] == VCMC_LIVE) |=> o_pic_load[2])
		else $error("live field not loaded");
	chk_strobe_no_spurious: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(chcfg_ff[0][1:0] == VCMC_STROBE && !ev_capture[0] && !ctrl_ff[2]) |=> !o_pic_load[0])
		else $error("strobe channel loaded without capture");
	chk_sim_together: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(ctrl_ff[2] && req_ff != 8'h00 && all_done) |=> (req_ff == 8'h00 && o_pic_load != 8'h00))
		else $error("simultaneous release failed");
	chk_aux_follows: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(mpp_ff == 4'h1) ##1 (mpp_ff == 4'h1) |-> o_aux_pins == $past(req_ff[1:0]))
		else $error("aux pins not showing flags");
	chk_switch_frozen: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		chcfg_ff[2][`VCMC_CH_FRZ_POS] |=> $stable(hold_src_ff[11:8]))
		else $error("frozen channel took switch");
	chk_reset_live: assert property (@(posedge i_clk)
		$rose(i_reset_n) |-> (chcfg_ff[0][1:0] == VCMC_LIVE && req_ff == 8'h00 && !ctrl_ff[2]))
		else $error("reset state wrong");
endmodule
`default_nettype wire

// File: sim/vcmc_video_src.sv
`timescale 1ns/1ps
`default_nettype none
module vcmc_video_src (
	// clock
	input wire logic i_clk,
	// per-channel field timing
	output logic [7:0] o_field_start,
	output logic [7:0] o_field_odd
);
	int cnt[8];
	initial begin
		o_field_start = 8'h00;
		o_field_odd = 8'h00;
		foreach (cnt[c]) cnt[c] = 0;
	end
	// lengths differ so channels drift apart after starting together
	always @(posedge i_clk) begin
		for (int c = 0; c < 8; c++) begin
			cnt[c] <= (cnt[c] >= 39 + 4 * c) ? 0 : cnt[c] + 1;
			o_field_start[c] <= (cnt[c] < 8);
			if (cnt[c] == 0) o_field_odd[c] <= ~o_field_odd[c];
		end
	end
endmodule
`default_nettype wire

// File: sim/vcmc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module vcmc_top_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] fs;
	logic [7:0] odd;
	logic [7:0] load;
	logic [7:0] sw_req = 8'h00;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] sw_src = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] pic_src;
	logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
	logic awr, wrdy, bv, arr, rv;
	logic [1:0] bresp, rresp, aux;
	logic [33:0] expq[$];
	int n_fail = 0;
	int n_compared = 0;
	always #25 clk = ~clk;
	vcmc_video_src vid (.i_clk(clk), .o_field_start(fs), .o_field_odd(odd));
	vcmc_top uut (
		.i_clk(clk), .i_reset_n(rst_n), .i_field_start(fs), .i_field_odd(odd),
		.i_switch_req(sw_req), .i_switch_src(sw_src),
		.i_awaddr(awaddr), .i_awvalid(awv), .o_awready(awr), .i_wdata(wdata),
		.i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wrdy), .o_bresp(bresp),
		.o_bvalid(bv), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arv),
		.o_arready(arr), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv),
		.i_rready(rready), .o_pic_src(pic_src), .o_pic_load(load), .o_aux_pins(aux)
	);
	task automatic final_report();
		if (n_fail == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= 500) begin
			n_fail++;
			$display("[FAIL] wait expected done seen timeout");
			final_report();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 500; n++) begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
			if (bv) break;
		end
		bready <= 1'b0;
		tmo(n);
		chk("bresp", {30'h0, r}, {30'h0, bresp});
	endtask
	// the note is queued before the request so the watcher always finds it
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		int n;
		@(posedge clk);
		expq.push_back({r, e});
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 500; n++) begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
			if (rv) break;
		end
		rready <= 1'b0;
		tmo(n);
	endtask
	always @(posedge clk) begin
		if (rv && rready) begin
			if (expq.size() == 0) begin
				chk("read count", 32'h0, 32'h1);
			end else begin
				chk("rdata", expq[0][31:0], rdata);
				chk("rresp", {30'h0, expq[0][33:32]}, {30'h0, rresp});
				void'(expq.pop_front());
			end
		end
	end
	task automatic wload(input logic [7:0] m);
		int n;
		for (n = 0; n < 500; n++) begin
			@(posedge clk);
			if ((load & m) != 8'h00) break;
		end
		tmo(n);
	endtask
	task automatic wrise(input int c);
		int n;
		logic p;
		p = 1'b1;
		for (n = 0; n < 500; n++) begin
			@(posedge clk);
			if (fs[c] && !p) break;
			p = fs[c];
		end
		tmo(n);
	endtask
	task automatic quiet(input int c, input int cyc);
		int k;
		k = 0;
		repeat (cyc) begin
			@(posedge clk);
			k += load[c];
		end
		chk("load count", 32'h0, k);
	endtask
	task automatic sw(input int c, input logic [3:0] s);
		@(posedge clk);
		sw_src[4 * c +: 4] <= s;
		sw_req[c] <= 1'b1;
		@(posedge clk);
		sw_req[c] <= 1'b0;
	endtask
	initial begin
		int s;
		void'($urandom(32'h1fd7346c));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h10, 32'h80, 2'b00);
		rd(8'h00, 32'h0, 2'b00);
		rd(8'h08, 32'h0, 2'b00);
		rd(8'h40, 32'hDEADBEEF, 2'b10);
		wr(8'h40, 32'h0, 2'b10);
		// second load only, the first may still carry the old source
		for (int c = 0; c < 8; c++) begin
			s = $urandom_range(7, 0);
			wr(8'(8'h10 + 4 * c), 32'h80 | ((s & 3) << 2) | ((s & 4) << 2));
			wload(8'h01 << c);
			wload(8'h01 << c);
			chk("pic_src", (c < 4) ? s : s & 3, {28'h0, pic_src[4 * c +: 4]});
		end
		wr(8'h0C, 32'h1);
		wr(8'h10, 32'h81);
		for (int f = 0; f < 4; f++) begin
			wr(8'h00, f);
			wrise(0);
			wr(8'h04, 32'h1);
			rd(8'h04, 32'h1, 2'b00);
			chk("aux", 32'h1, {30'h0, aux});
			wr(8'h10, 32'h80);
			rd(8'h10, 32'h81, 2'b00);
			wload(8'h01);
			if (f != 2) chk("field odd", (f == 0), odd[0]);
			rd(8'h08, 32'h0, 2'b00);
		end
		quiet(0, 200);
		wr(8'h04, 32'h2);
		rd(8'h04, 32'h0, 2'b00);
		wr(8'h10, 32'hA1);
		wr(8'h04, 32'h1);
		rd(8'h04, 32'h0, 2'b00);
		wr(8'h10, 32'h81);
		wr(8'h14, 32'h81);
		wr(8'h00, 32'h6);
		wr(8'h04, 32'h3);
		wload(8'h03);
		chk("joint load", 32'h3, {30'h0, load[1:0]});
		rd(8'h08, 32'h0, 2'b00);
		wr(8'h18, 32'h82);
		wr(8'h00, 32'h8);
		sw(2, 4'h5);
		wload(8'h04);
		wload(8'h04);
		chk("switch src", 32'h5, {28'h0, pic_src[11:8]});
		wr(8'h00, 32'h0);
		quiet(2, 150);
		sw(2, 4'h6);
		wload(8'h04);
		chk("switch src", 32'h6, {28'h0, pic_src[11:8]});
		wr(8'h18, 32'hA2);
		sw(2, 4'h1);
		quiet(2, 150);
		chk("switch src", 32'h6, {28'h0, pic_src[11:8]});
		wr(8'h18, 32'h82);
		wr(8'h00, 32'h10);
		sw(2, 4'h7);
		wload(8'h04);
		chk("frame switch src", 32'h7, {28'h0, pic_src[11:8]});
		chk("frame switch odd", 32'h0, {31'h0, odd[2]});
		final_report();
	end
endmodule
`default_nettype wire
